// >>> shared/mfs_pkg.sv
// Constants and types for the motor fault supervisor
package mfs_pkg;
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned TICK_PERIOD_NS = 1_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Widths
    localparam int ADC_W = 12;
    localparam int CNT_W = 16;
    localparam int ADR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_UV     = 8'h04;
    localparam logic [7:0] OFS_OV     = 8'h08;
    localparam logic [7:0] OFS_ILIM   = 8'h0C;
    localparam logic [7:0] OFS_MINREV = 8'h10;
    localparam logic [7:0] OFS_WIN    = 8'h14;
    localparam logic [7:0] OFS_RECOV  = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_REVCNT = 8'h20;

    // Field positions
    localparam int CTRL_RUN_BIT     = 0;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_CAUSE_LSB = 4;

    // Reset values
    localparam logic [11:0] UV_RST     = 12'h02C8;
    localparam logic [11:0] OV_RST     = 12'h0590;
    localparam logic [11:0] ILIM_RST   = 12'h012C;
    localparam logic [15:0] MINREV_RST = 16'h0001;
    localparam logic [15:0] WIN_RST    = 16'h03E8;
    localparam logic [15:0] RECOV_RST  = 16'h0BB8;

    // Amplifier gain code for 5 V/V (code value is arbitrary)
    localparam logic [1:0] GAIN_5VV = 2'h1;
    // Commutation phase code for phase A
    localparam logic [1:0] PHASE_A  = 2'h0;

    // Supervisor states, Gray along init-run-fault-reinit
    typedef enum logic [1:0] {
        ST_INIT   = 2'h0,
        ST_RUN    = 2'h1,
        ST_FAULT  = 2'h3,
        ST_REINIT = 2'h2
    } mfs_state_t;

    // One ADC sample with its strobe
    typedef struct packed {
        logic             valid;
        logic [ADC_W-1:0] data;
    } mfs_sample_t;

    // Fault causes
    typedef struct packed {
        logic stall;
        logic overcur;
        logic ov;
        logic uv;
    } mfs_cause_t;
endpackage

// >>> verilog/mfs_supervisor.sv
// Motor fault supervisor with APB register slave
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

// Function
// - Supply below low limit forces fault
// - Supply above high limit forces fault
// - Supply limits held as 12-bit counts
// - Count revolutions, stalled if below minimum
// - One millisecond tick advances stall window
// - At window end, too few revolutions faults
// - Phase A current sampled once, limit faults
// - Current limit held as 12-bit counts
// - Set amplifier gain 5 V/V before monitoring (here gain_wr pulses in the first run cycle, as monitoring starts)
// - Reinitialise after recovery tick count elapses
module mfs_supervisor #(
    parameter int unsigned TICK_CYCLES = mfs_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Sensing inputs
    input  wire mfs_pkg::mfs_sample_t supply_smp,
    input  wire mfs_pkg::mfs_sample_t current_smp,
    input  wire logic [1:0]           phase_sel,
    input  wire logic                 rev_done,
    // Drive outputs
    output logic                      predrv_off,
    output logic                      reinit_req,
    output logic                      gain_wr,
    output logic      [1:0]           gain_code
);
    localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    // True for an offset that holds a register
    function automatic logic is_mapped(input logic [7:0] a);
        return a inside {mfs_pkg::OFS_CTRL, mfs_pkg::OFS_UV,
                         mfs_pkg::OFS_OV, mfs_pkg::OFS_ILIM,
                         mfs_pkg::OFS_MINREV, mfs_pkg::OFS_WIN,
                         mfs_pkg::OFS_RECOV, mfs_pkg::OFS_STATUS,
                         mfs_pkg::OFS_REVCNT};
    endfunction

    mfs_pkg::mfs_state_t state_ff, nxt_state;
    logic              run_en_ff, nxt_run_en;
    logic [11:0]       uv_ff, nxt_uv;
    logic [11:0]       ov_ff, nxt_ov;
    logic [11:0]       ilim_ff, nxt_ilim;
    logic [15:0]       minrev_ff, nxt_minrev;
    logic [15:0]       win_ff, nxt_win;
    logic [15:0]       recov_ff, nxt_recov;
    mfs_pkg::mfs_cause_t cause_ff, nxt_cause;
    logic [31:0]       prdata_ff, nxt_prdata;
    logic [TW-1:0]     tick_cnt_ff, nxt_tick_cnt;
    logic [15:0]       win_cnt_ff, nxt_win_cnt;
    logic [15:0]       rev_cnt_ff, nxt_rev_cnt;
    logic [15:0]       rec_cnt_ff, nxt_rec_cnt;
    logic              armed_ff, nxt_armed;
    logic              reinit_ff, nxt_reinit;
    logic              gain_wr_ff, nxt_gain_wr;
    logic [1:0]        gain_ff, nxt_gain;
    logic              wr_en;
    logic              tick;
    logic              running;
    logic              take_cur;
    logic              win_end;
    logic              rec_end;
    mfs_pkg::mfs_cause_t det;

    // APB answers in the access cycle with no wait states
    assign wr_en   = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~is_mapped(paddr);
    assign prdata  = prdata_ff;

    // Free running millisecond tick
    assign tick = (tick_cnt_ff == TICK_LAST);

    // Fault detection, only while running
    assign running  = (state_ff == mfs_pkg::ST_RUN);
    assign take_cur = running & current_smp.valid &
                      (phase_sel == mfs_pkg::PHASE_A) & armed_ff;
    assign win_end  = running & tick &
                      (16'(win_cnt_ff + 16'h0001) >= win_ff);
    assign rec_end  = (state_ff == mfs_pkg::ST_FAULT) & tick &
                      (16'(rec_cnt_ff + 16'h0001) >= recov_ff);

    always_comb begin
        det.uv    = running & supply_smp.valid &
                    (supply_smp.data < uv_ff);
        det.ov    = running & supply_smp.valid &
                    (supply_smp.data > ov_ff);
        det.overcur = take_cur & (current_smp.data >= ilim_ff);
        det.stall = win_end & (rev_cnt_ff < minrev_ff);
    end

    // Register file next values
    always_comb begin
        nxt_run_en = run_en_ff;
        nxt_uv     = uv_ff;
        nxt_ov     = ov_ff;
        nxt_ilim   = ilim_ff;
        nxt_minrev = minrev_ff;
        nxt_win    = win_ff;
        nxt_recov  = recov_ff;
        nxt_prdata = prdata_ff;
        nxt_cause  = cause_ff;
        if (wr_en) begin
            unique case (paddr)
                mfs_pkg::OFS_CTRL:   nxt_run_en = pwdata[mfs_pkg::CTRL_RUN_BIT];
                mfs_pkg::OFS_UV:     nxt_uv = pwdata[11:0];
                mfs_pkg::OFS_OV:     nxt_ov = pwdata[11:0];
                mfs_pkg::OFS_ILIM:   nxt_ilim = pwdata[11:0];
                mfs_pkg::OFS_MINREV: nxt_minrev = pwdata[15:0];
                mfs_pkg::OFS_WIN:    nxt_win = pwdata[15:0];
                mfs_pkg::OFS_RECOV:  nxt_recov = pwdata[15:0];
                mfs_pkg::OFS_STATUS: nxt_cause = cause_ff &
                    ~pwdata[mfs_pkg::STATUS_CAUSE_LSB +: 4];
                default: ;
            endcase
        end
        // Causes latch on fault entry; a set beats a clear
        if (running && (det != '0)) begin
            nxt_cause = nxt_cause | det;
        end
        // Read data captured in the setup cycle
        if (psel && !penable && !pwrite) begin
            nxt_prdata = 32'h0000_0000;
            unique case (paddr)
                mfs_pkg::OFS_CTRL:   nxt_prdata[0] = run_en_ff;
                mfs_pkg::OFS_UV:     nxt_prdata[11:0] = uv_ff;
                mfs_pkg::OFS_OV:     nxt_prdata[11:0] = ov_ff;
                mfs_pkg::OFS_ILIM:   nxt_prdata[11:0] = ilim_ff;
                mfs_pkg::OFS_MINREV: nxt_prdata[15:0] = minrev_ff;
                mfs_pkg::OFS_WIN:    nxt_prdata[15:0] = win_ff;
                mfs_pkg::OFS_RECOV:  nxt_prdata[15:0] = recov_ff;
                mfs_pkg::OFS_STATUS: begin
                    nxt_prdata[mfs_pkg::STATUS_STATE_LSB +: 2] = state_ff;
                    nxt_prdata[mfs_pkg::STATUS_CAUSE_LSB +: 4] = cause_ff;
                end
                mfs_pkg::OFS_REVCNT: nxt_prdata[15:0] = rev_cnt_ff;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_en_ff <= 1'b0;
            uv_ff     <= mfs_pkg::UV_RST;
            ov_ff     <= mfs_pkg::OV_RST;
            ilim_ff   <= mfs_pkg::ILIM_RST;
            minrev_ff <= mfs_pkg::MINREV_RST;
            win_ff    <= mfs_pkg::WIN_RST;
            recov_ff  <= mfs_pkg::RECOV_RST;
            prdata_ff <= 32'h0000_0000;
            cause_ff  <= '0;
        end else begin
            run_en_ff <= nxt_run_en;
            uv_ff     <= nxt_uv;
            ov_ff     <= nxt_ov;
            ilim_ff   <= nxt_ilim;
            minrev_ff <= nxt_minrev;
            win_ff    <= nxt_win;
            recov_ff  <= nxt_recov;
            prdata_ff <= nxt_prdata;
            cause_ff  <= nxt_cause;
        end
    end

    // Supervisor state, counters and drive outputs
    always_comb begin
        nxt_state    = state_ff;
        nxt_tick_cnt = tick ? '0 : TW'(tick_cnt_ff + 1'b1);
        nxt_win_cnt  = win_cnt_ff;
        nxt_rev_cnt  = rev_cnt_ff;
        nxt_rec_cnt  = rec_cnt_ff;
        nxt_armed    = armed_ff;
        nxt_reinit   = 1'b0;
        nxt_gain_wr  = 1'b0;
        nxt_gain     = gain_ff;
        unique case (state_ff)
            mfs_pkg::ST_INIT: begin
                nxt_win_cnt = 16'h0000;
                nxt_rev_cnt = 16'h0000;
                nxt_armed   = 1'b1;
                if (run_en_ff) begin
                    nxt_gain    = mfs_pkg::GAIN_5VV;
                    nxt_gain_wr = 1'b1;
                    nxt_state   = mfs_pkg::ST_RUN;
                end
            end
            mfs_pkg::ST_RUN: begin
                if (rev_done && rev_cnt_ff != 16'hFFFF) begin
                    nxt_rev_cnt = 16'(rev_cnt_ff + 16'h0001);
                end
                if (tick) begin
                    nxt_win_cnt = 16'(win_cnt_ff + 16'h0001);
                end
                if (win_end) begin
                    nxt_win_cnt = 16'h0000;
                    nxt_rev_cnt = 16'h0000;
                end
                // Re-arm once phase A is left
                if (phase_sel != mfs_pkg::PHASE_A) begin
                    nxt_armed = 1'b1;
                end else if (take_cur) begin
                    nxt_armed = 1'b0;
                end
                if (det != '0) begin
                    nxt_rec_cnt = 16'h0000;
                    nxt_state   = mfs_pkg::ST_FAULT;
                end
            end
            mfs_pkg::ST_FAULT: begin
                if (tick) begin
                    nxt_rec_cnt = 16'(rec_cnt_ff + 16'h0001);
                end
                if (rec_end) begin
                    nxt_reinit = 1'b1;
                    nxt_state  = mfs_pkg::ST_REINIT;
                end
            end
            mfs_pkg::ST_REINIT: nxt_state = mfs_pkg::ST_INIT;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff    <= mfs_pkg::ST_INIT;
            tick_cnt_ff <= '0;
            win_cnt_ff  <= 16'h0000;
            rev_cnt_ff  <= 16'h0000;
            rec_cnt_ff  <= 16'h0000;
            armed_ff    <= 1'b1;
            reinit_ff   <= 1'b0;
            gain_wr_ff  <= 1'b0;
            gain_ff     <= 2'h0;
        end else begin
            state_ff    <= nxt_state;
            tick_cnt_ff <= nxt_tick_cnt;
            win_cnt_ff  <= nxt_win_cnt;
            rev_cnt_ff  <= nxt_rev_cnt;
            rec_cnt_ff  <= nxt_rec_cnt;
            armed_ff    <= nxt_armed;
            reinit_ff   <= nxt_reinit;
            gain_wr_ff  <= nxt_gain_wr;
            gain_ff     <= nxt_gain;
        end
    end

    // Predrivers run only in the run state
    assign predrv_off = (state_ff != mfs_pkg::ST_RUN);
    assign reinit_req = reinit_ff;
    assign gain_wr    = gain_wr_ff;
    assign gain_code  = gain_ff;

    // Checks
    AST_UNDERVOLT: assert property (@(posedge clock) disable iff (rst)
        running && supply_smp.valid && supply_smp.data < uv_ff
        |=> state_ff == mfs_pkg::ST_FAULT && cause_ff.uv && predrv_off)
        else $error("undervoltage did not fault");
    AST_OVERVOLT: assert property (@(posedge clock) disable iff (rst)
        running && supply_smp.valid && supply_smp.data > ov_ff
        |=> state_ff == mfs_pkg::ST_FAULT && cause_ff.ov)
        else $error("overvoltage did not fault");
    AST_LIMIT_HOLD: assert property (@(posedge clock) disable iff (rst)
        !(wr_en && paddr == mfs_pkg::OFS_UV) |=> $stable(uv_ff))
        else $error("undervoltage limit changed without write");
    AST_TICK_GAP: assert property (@(posedge clock) disable iff (rst)
        tick |=> !tick [*8])
        else $error("tick repeats too soon");
    AST_STALL: assert property (@(posedge clock) disable iff (rst)
        win_end && rev_cnt_ff < minrev_ff
        |=> state_ff == mfs_pkg::ST_FAULT && cause_ff.stall)
        else $error("stall not detected at window end");
    AST_OVERCUR: assert property (@(posedge clock) disable iff (rst)
        take_cur && current_smp.data >= ilim_ff
        |=> state_ff == mfs_pkg::ST_FAULT ##1 predrv_off)
        else $error("overcurrent did not fault");
    AST_GAIN_FIRST: assert property (@(posedge clock) disable iff (rst)
        $rose(running) |-> gain_wr && gain_code == mfs_pkg::GAIN_5VV)
        else $error("monitoring began without gain setup");
    AST_RECOVER: assert property (@(posedge clock) disable iff (rst)
        rec_end |=> reinit_req && state_ff == mfs_pkg::ST_REINIT
        ##1 !reinit_req && state_ff == mfs_pkg::ST_INIT)
        else $error("recovery did not reinitialise");
    AST_FAULT_HOLD: assert property (@(posedge clock) disable iff (rst)
        state_ff == mfs_pkg::ST_FAULT && !rec_end
        |=> state_ff == mfs_pkg::ST_FAULT && predrv_off &&
            ($stable(cause_ff) || $past(wr_en)))
        else $error("fault state left early");
endmodule

// >>> tb/mfs_drive_model.sv
// Behavioural model of the sensing front end and the amplifier
`timescale 1ns/1ps
module mfs_drive_model (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // Amplifier set-up from the supervisor
    input  wire logic                 gain_wr,
    input  wire logic [1:0]           gain_code,
    // Sensing outputs
    output mfs_pkg::mfs_sample_t      supply_smp,
    output mfs_pkg::mfs_sample_t      current_smp,
    output logic      [1:0]           phase_sel,
    output logic                      rev_done
);
    logic       spin;
    logic [1:0] amp_gain;
    logic [2:0] rev_div;

    // Idle sensing values at time zero
    initial begin
        spin        = 1'b1;
        phase_sel   = 2'h1;
        supply_smp  = '{valid: 1'b0, data: 12'h0800};
        current_smp = '{valid: 1'b0, data: 12'h0000};
    end

    // Rotor turning once every eight clocks while spinning
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rev_div  <= 3'h0;
            rev_done <= 1'b0;
        end else begin
            rev_div  <= rev_div + 3'h1;
            rev_done <= spin && (rev_div == 3'h7);
        end
    end

    // Amplifier keeps the last gain written to it
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            amp_gain <= 2'h0;
        end else if (gain_wr) begin
            amp_gain <= gain_code;
        end
    end

    // Commutation phase change at a clock edge
    task automatic phase(input logic [1:0] p);
        @(posedge clock);
        phase_sel <= p;
    endtask

    // One-cycle sample strobe; data scrambled once the strobe ends
    task automatic strobe(input logic cur, input logic [11:0] v);
        @(posedge clock);
        if (cur) current_smp <= '{valid: 1'b1, data: v};
        else supply_smp <= '{valid: 1'b1, data: v};
        @(posedge clock);
        if (cur) current_smp <= '{valid: 1'b0, data: ~v};
        else supply_smp <= '{valid: 1'b0, data: ~v};
    endtask
endmodule

// >>> tb/mfs_supervisor_test.sv
// Self-checking testbench for the motor fault supervisor
`timescale 1ns/1ps
module mfs_supervisor_test;
    localparam int TICKS = 16;
    localparam int RECOV = 5;
    localparam int LIMIT = 5000;
    logic                 clock;
    logic                 rst;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    mfs_pkg::mfs_sample_t supply_smp;
    mfs_pkg::mfs_sample_t current_smp;
    logic [1:0]           phase_sel;
    logic                 rev_done;
    logic                 predrv_off;
    logic                 reinit_req;
    logic                 gain_wr;
    logic [1:0]           gain_code;
    int                   error_cnt = 0;
    int                   tests_run = 0;
    int                   cyc = 0;
    int                   i;
    int                   n;
    logic [7:0]           ofs [9];
    logic [31:0]          rval [9];
    logic [31:0]          rdv;
    logic                 rerr;

    mfs_supervisor #(.TICK_CYCLES(TICKS)) mfs_supervisor_i (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_smp(supply_smp),
        .current_smp(current_smp), .phase_sel(phase_sel),
        .rev_done(rev_done), .predrv_off(predrv_off),
        .reinit_req(reinit_req), .gain_wr(gain_wr), .gain_code(gain_code));
    mfs_drive_model mfs_drive_model_i (
        .clock(clock), .rst(rst), .gain_wr(gain_wr),
        .gain_code(gain_code), .supply_smp(supply_smp),
        .current_smp(current_smp), .phase_sel(phase_sel),
        .rev_done(rev_done));

    // Clock and hang guard
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            conclude();
        end
    end

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, v, d, e);
        check("write error", 32'(e), 32'h0000_0000);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, d, e);
        check(what, d, exp);
    endtask

    // Fault just raised: hold-off, recovery time, restart, sticky cause
    task automatic fault_cycle(input string what, input logic [3:0] cause,
                               input logic [11:0] ign);
        logic lost;
        int   k;
        #1;
        check(what, 32'(predrv_off), 32'h0000_0001);
        lost = 1'b0;
        mfs_drive_model_i.strobe(1'b0, ign);
        k = 2;
        while (reinit_req !== 1'b1 && k < 1000) begin
            @(posedge clock);
            #1;
            k++;
            if (predrv_off !== 1'b1) lost = 1'b1;
        end
        check("held off", 32'(lost), 32'h0000_0000);
        check("recovery early", 32'(k >= (RECOV - 1) * TICKS), 32'h1);
        check("recovery late", 32'(k <= RECOV * TICKS + 4), 32'h1);
        @(posedge clock);
        #1;
        check("reinit pulse", 32'(reinit_req), 32'h0000_0000);
        for (k = 0; k < 8 && predrv_off !== 1'b0; k++) @(posedge clock);
        check("restart", 32'(predrv_off), 32'h0000_0000);
        rd_chk("cause", mfs_pkg::OFS_STATUS, {24'h0, cause, 4'h1});
        wr(mfs_pkg::OFS_STATUS, 32'h0000_00F0);
        rd_chk("cleared", mfs_pkg::OFS_STATUS, 32'h0000_0001);
        $display("test %s done", what);
    endtask

    // Verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ofs = '{mfs_pkg::OFS_CTRL, mfs_pkg::OFS_UV, mfs_pkg::OFS_OV,
                mfs_pkg::OFS_ILIM, mfs_pkg::OFS_MINREV, mfs_pkg::OFS_WIN,
                mfs_pkg::OFS_RECOV, mfs_pkg::OFS_STATUS, mfs_pkg::OFS_REVCNT};
        rval = '{32'h0000_0000, 32'h0000_02C8, 32'h0000_0590,
                 32'h0000_012C, 32'h0000_0001, 32'h0000_03E8,
                 32'h0000_0BB8, 32'h0000_0000, 32'h0000_0000};
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 9; i++) rd_chk("reset value", ofs[i], rval[i]);
        check("gain at reset", 32'(gain_code), 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000, rdv, rerr);
        check("unmapped", rdv, 32'h0000_0000);
        check("unmapped error", 32'(rerr), 32'h0000_0001);
        $display("test registers done");
        // Short window and recovery, then start the drive
        wr(mfs_pkg::OFS_WIN, 32'h0000_0004);
        wr(mfs_pkg::OFS_RECOV, 32'h0000_0005);
        wr(mfs_pkg::OFS_CTRL, 32'h0000_0001);
        for (n = 0; n < 20 && gain_wr !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        check("gain code", 32'(gain_code), 32'(mfs_pkg::GAIN_5VV));
        check("drive on", 32'(predrv_off), 32'h0000_0000);
        @(posedge clock);
        #1;
        check("amp gain", 32'(mfs_drive_model_i.amp_gain), 32'h1);
        // Supply limits: boundary passes, one count beyond faults
        mfs_drive_model_i.strobe(1'b0, 12'h02C8);
        #1;
        check("uv edge", 32'(predrv_off), 32'h0000_0000);
        mfs_drive_model_i.strobe(1'b0, 12'h02C7);
        fault_cycle("undervoltage", 4'h1, 12'hFFF);
        mfs_drive_model_i.strobe(1'b0, 12'h0590);
        #1;
        check("ov edge", 32'(predrv_off), 32'h0000_0000);
        mfs_drive_model_i.strobe(1'b0, 12'h0591);
        fault_cycle("overvoltage", 4'h2, 12'h0000);
        // Current: other phase and second sample ignored, limit faults
        mfs_drive_model_i.phase(2'h1);
        mfs_drive_model_i.strobe(1'b1, 12'h012C);
        mfs_drive_model_i.phase(mfs_pkg::PHASE_A);
        mfs_drive_model_i.strobe(1'b1, 12'h012B);
        mfs_drive_model_i.strobe(1'b1, 12'h012C);
        #1;
        check("oc once", 32'(predrv_off), 32'h0000_0000);
        mfs_drive_model_i.phase(2'h1);
        mfs_drive_model_i.phase(mfs_pkg::PHASE_A);
        mfs_drive_model_i.strobe(1'b1, 12'h012C);
        fault_cycle("overcurrent", 4'h4, 12'h0000);
        // Stall: rotor stops, fault within two windows
        @(posedge clock);
        mfs_drive_model_i.spin <= 1'b0;
        for (n = 0; n < 2 * 4 * TICKS + 8 && predrv_off !== 1'b1; n++)
            @(posedge clock);
        check("stall seen", 32'(predrv_off), 32'h0000_0001);
        mfs_drive_model_i.spin <= 1'b1;
        fault_cycle("stall", 4'h8, 12'h0000);
        conclude();
    end
endmodule
